// ### asrc_mem_model.sv
`timescale 1ns/1ps
module asrc_mem_model (
  input wire logic clk, // Sampling clock for the clash monitor
  input wire logic cs_n, // Chip select
  input wire logic we_n, // Write enable
  input wire logic oe_n, // Output enable
  input wire logic ub_n, // Upper lane enable
  input wire logic lb_n, // Lower lane enable
  input wire logic ctrl_oe, // Controller drives the bus
  input wire logic [16:0] addr, // Address pins
  input wire logic [15:0] wdata, // Resolved bus
  output logic [15:0] q, // Read data
  output logic [1:0] q_en, // Lane drive, bit1 upper
  output logic clash // Sticky: both sides drove
);
  logic hit = 1'b0;
  assign clash = hit;
  logic [15:0] mem [logic [16:0]]; // No correction modelled, no write-back
  logic win, drive;
  logic [16:0] wa;
  logic [15:0] wd, rd;
  logic [1:0] wl = 2'h0;
  assign win = !cs_n && !we_n && !(ub_n && lb_n);
  assign drive = !cs_n && !oe_n && we_n;
  assign q_en = {drive && !ub_n, drive && !lb_n};
  always @* if (win) begin
    wa = addr;
    wd = wdata;
    wl = {!ub_n, !lb_n};
  end
  // Commit on first rising control edge, data as seen then
  always @(negedge win) if (wl != 2'h0) begin
    rd = mem.exists(wa) ? mem[wa] : 16'h0;
    if (wl[0]) rd[7:0] = wd[7:0];
    if (wl[1]) rd[15:8] = wd[15:8];
    mem[wa] = rd;
  end
  always @(addr, q_en) q = mem.exists(addr) ? mem[addr] : 16'h0;
  always @(negedge clk) if (ctrl_oe && q_en != 2'h0) hit <= 1'b1;
endmodule

// ### asrc_pkg.sv
package asrc_pkg;
  localparam int ASRC_ADDR_W = 17;
  localparam int ASRC_DATA_W = 16;
  localparam int ASRC_LANE_W = 8;
  localparam int ASRC_CLK_PERIOD_PS = 40000;
  // Grade timing figures, 10 ns grade, in picoseconds
  localparam int ASRC_WRITE_PULSE_WIDTH_PS = 7000;
  localparam int ASRC_SELECT_LOW_TO_WRITE_END_PS = 7000;
  localparam int ASRC_LANE_ENABLE_TO_WRITE_END_PS = 7000;
  localparam int ASRC_DATA_SETUP_BEFORE_WRITE_END_PS = 5000;
  localparam int ASRC_WRITE_LOW_TO_FLOAT_TIME_PS = 5000;
  localparam int ASRC_READ_CYCLE_PS = 10000;
  localparam int ASRC_ADDR_TO_DATA_PS = 10000;
  localparam int ASRC_BUS_TURN_PS = 5000;
  // Least times round up, never below one cycle
  function automatic int asrc_cycles(input int ps);
    int c;
    c = (ps + ASRC_CLK_PERIOD_PS - 1) / ASRC_CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int ASRC_WR_PULSE_CYC = asrc_cycles(ASRC_DATA_SETUP_BEFORE_WRITE_END_PS
                                                 + ASRC_WRITE_LOW_TO_FLOAT_TIME_PS);
  localparam int ASRC_WR_SEL_CYC = asrc_cycles(ASRC_SELECT_LOW_TO_WRITE_END_PS);
  localparam int ASRC_WR_LANE_CYC = asrc_cycles(ASRC_LANE_ENABLE_TO_WRITE_END_PS);
  localparam int ASRC_WR_MIN_CYC = asrc_cycles(ASRC_WRITE_PULSE_WIDTH_PS);
  localparam int ASRC_RD_CYC = asrc_cycles(ASRC_ADDR_TO_DATA_PS);
  localparam int ASRC_TURN_CYC = asrc_cycles(ASRC_BUS_TURN_PS);
  localparam int ASRC_CNT_W = 4;
  localparam logic [1:0] ASRC_LANES_OFF = 2'h3;
  typedef enum logic [2:0] {
    ASRC_IDLE = 3'h0,
    ASRC_RD_ACCESS = 3'h1,
    ASRC_RD_DONE = 3'h3,
    ASRC_WR_SETUP = 3'h4,
    ASRC_WR_PULSE = 3'h5,
    ASRC_WR_HOLD = 3'h7,
    ASRC_TURN = 3'h2
  } asrc_state_e;
endpackage

// ### asrc_sram_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Write needs select, write, lane low together
// - Write ends on first rising control edge
// - Data timed from the terminating edge
// - Never drive while memory drives bus
// - Write enable high throughout every read
// - Address valid before select falls on writes; reads set both on the same edge
// - Write pulse covers setup plus float time
// - Select low long enough before write end
// - Lane enable low long enough before end
module asrc_sram_ctrl
  import asrc_pkg::*;
#(
  parameter int ADDR_W = asrc_pkg::ASRC_ADDR_W,
  parameter int DATA_W = asrc_pkg::ASRC_DATA_W
) (
  input wire logic core_clk, // 25 MHz clock
  input wire logic reset_n, // Async reset, active low
  input wire logic req_valid, // Access request
  input wire logic req_write, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] req_addr, // Word address
  input wire logic [DATA_W-1:0] req_wdata, // Write data
  input wire logic [1:0] req_lane, // Lane select, bit1 upper, active high
  output logic req_ready, // Idle, request taken
  output logic rsp_valid, // Read data pulse
  output logic [DATA_W-1:0] rsp_rdata, // Read data, disabled lanes zero
  output logic wr_done, // Write finished pulse
  output logic chip_select_n, // Memory chip select
  output logic write_enable_n, // Memory write enable
  output logic output_enable_n, // Memory output enable
  output logic upper_byte_lane_n, // Upper lane enable
  output logic lower_byte_lane_n, // Lower lane enable
  output logic [ADDR_W-1:0] address_bus, // Memory address
  output logic [DATA_W-1:0] data_bus_out, // Data driven to memory
  output logic data_bus_oe, // High while driving data
  input wire logic [DATA_W-1:0] data_bus_in // Data from memory
);
  import asrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  asrc_state_e state;
  asrc_state_e next_state;
  logic [1:0] lane;
  logic [1:0] next_lane;
  logic next_req_ready;
  logic next_rsp_valid;
  logic [DATA_W-1:0] next_rsp_rdata;
  logic next_wr_done;
  logic next_chip_select_n;
  logic next_write_enable_n;
  logic next_output_enable_n;
  logic next_upper_byte_lane_n;
  logic next_lower_byte_lane_n;
  logic [ADDR_W-1:0] next_address_bus;
  logic [DATA_W-1:0] next_data_bus_out;
  logic next_data_bus_oe;
  logic tmr_load;
  logic [ASRC_CNT_W-1:0] tmr_value;
  logic tmr_expired;

  // Keeps only the lanes actually read
  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] sel,
                                                  input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] m;
    m = '0;
    if (sel[0]) m[ASRC_LANE_W-1:0] = d[ASRC_LANE_W-1:0];
    if (sel[1]) m[DATA_W-1:ASRC_LANE_W] = d[DATA_W-1:ASRC_LANE_W];
    return m;
  endfunction

  localparam int WR_LOW_CYC_RAW = (ASRC_WR_PULSE_CYC > ASRC_WR_SEL_CYC) ?
                                  ASRC_WR_PULSE_CYC : ASRC_WR_SEL_CYC;
  localparam int WR_LOW_CYC_A = (WR_LOW_CYC_RAW > ASRC_WR_LANE_CYC) ?
                                WR_LOW_CYC_RAW : ASRC_WR_LANE_CYC;
  localparam int WR_LOW_CYC = (WR_LOW_CYC_A > ASRC_WR_MIN_CYC) ? WR_LOW_CYC_A : ASRC_WR_MIN_CYC;

  asrc_wait_timer #(
    .WIDTH(ASRC_CNT_W)
  ) u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(tmr_load),
    .load_value(tmr_value),
    .expired(tmr_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_lane = lane;
    next_req_ready = req_ready;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    next_wr_done = 1'b0;
    next_chip_select_n = chip_select_n;
    next_write_enable_n = write_enable_n;
    next_output_enable_n = output_enable_n;
    next_upper_byte_lane_n = upper_byte_lane_n;
    next_lower_byte_lane_n = lower_byte_lane_n;
    next_address_bus = address_bus;
    next_data_bus_out = data_bus_out;
    next_data_bus_oe = data_bus_oe;
    tmr_load = 1'b0;
    tmr_value = '0;
    unique case (state)
      ASRC_IDLE: begin
        if (req_valid && req_ready && req_lane != 2'h0) begin
          next_req_ready = 1'b0;
          next_lane = req_lane;
          next_address_bus = req_addr;
          if (req_write) begin
            // Output enable high so the memory floats during the write
            next_output_enable_n = 1'b1;
            next_data_bus_out = req_wdata;
            next_state = ASRC_WR_SETUP;
          end else begin
            next_write_enable_n = 1'b1;
            next_chip_select_n = 1'b0;
            next_output_enable_n = 1'b0;
            next_lower_byte_lane_n = !req_lane[0];
            next_upper_byte_lane_n = !req_lane[1];
            tmr_load = 1'b1;
            tmr_value = ASRC_CNT_W'(ASRC_RD_CYC);
            next_state = ASRC_RD_ACCESS;
          end
        end
      end
      ASRC_RD_ACCESS: begin
        if (tmr_expired) begin
          next_state = ASRC_RD_DONE;
        end
      end
      ASRC_RD_DONE: begin
        // Error correction is internal; data is taken as delivered
        next_rsp_rdata = lane_mask(lane, data_bus_in);
        next_rsp_valid = 1'b1;
        next_chip_select_n = 1'b1;
        next_output_enable_n = 1'b1;
        next_lower_byte_lane_n = 1'b1;
        next_upper_byte_lane_n = 1'b1;
        tmr_load = 1'b1;
        tmr_value = ASRC_CNT_W'(ASRC_TURN_CYC);
        next_state = ASRC_TURN;
      end
      ASRC_WR_SETUP: begin
        // Address settles a cycle before select falls; data drive starts with select
        next_data_bus_oe = 1'b1;
        next_chip_select_n = 1'b0;
        next_write_enable_n = 1'b0;
        next_lower_byte_lane_n = !lane[0];
        next_upper_byte_lane_n = !lane[1];
        tmr_load = 1'b1;
        tmr_value = ASRC_CNT_W'(WR_LOW_CYC);
        next_state = ASRC_WR_PULSE;
      end
      ASRC_WR_PULSE: begin
        if (tmr_expired) begin
          // Write enable alone terminates; data held past that edge
          next_write_enable_n = 1'b1;
          next_state = ASRC_WR_HOLD;
        end
      end
      ASRC_WR_HOLD: begin
        next_chip_select_n = 1'b1;
        next_lower_byte_lane_n = 1'b1;
        next_upper_byte_lane_n = 1'b1;
        next_data_bus_oe = 1'b0;
        next_wr_done = 1'b1;
        tmr_load = 1'b1;
        tmr_value = ASRC_CNT_W'(ASRC_TURN_CYC);
        next_state = ASRC_TURN;
      end
      ASRC_TURN: begin
        // Gap lets the memory float before anyone drives again
        if (tmr_expired) begin
          next_req_ready = 1'b1;
          next_state = ASRC_IDLE;
        end
      end
      default: begin
        next_state = ASRC_IDLE;
        next_req_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ASRC_IDLE;
      lane <= 2'h0;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      wr_done <= 1'b0;
      chip_select_n <= 1'b1;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      upper_byte_lane_n <= ASRC_LANES_OFF[1];
      lower_byte_lane_n <= ASRC_LANES_OFF[0];
      address_bus <= '0;
      data_bus_out <= '0;
      data_bus_oe <= 1'b0;
    end else begin
      state <= next_state;
      lane <= next_lane;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      wr_done <= next_wr_done;
      chip_select_n <= next_chip_select_n;
      write_enable_n <= next_write_enable_n;
      output_enable_n <= next_output_enable_n;
      upper_byte_lane_n <= next_upper_byte_lane_n;
      lower_byte_lane_n <= next_lower_byte_lane_n;
      address_bus <= next_address_bus;
      data_bus_out <= next_data_bus_out;
      data_bus_oe <= next_data_bus_oe;
    end
  end
endmodule

// ### asrc_sram_ctrl_checker.sv
`timescale 1ns/1ps
module asrc_sram_ctrl_checker #(
  parameter int ADDR_W = asrc_pkg::ASRC_ADDR_W,
  parameter int DATA_W = asrc_pkg::ASRC_DATA_W
) (
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Async reset, active low
  input wire logic req_valid, // Access request
  input wire logic req_write, // 1 write, 0 read
  input wire logic req_ready, // Idle, request taken
  input wire logic rsp_valid, // Read data pulse
  input wire logic wr_done, // Write finished pulse
  input wire logic [1:0] req_lane, // Lane select
  input wire logic [ADDR_W-1:0] req_addr, // Word address
  input wire logic [ADDR_W-1:0] address_bus, // Memory address
  input wire logic [DATA_W-1:0] req_wdata, // Write data
  input wire logic [DATA_W-1:0] rsp_rdata, // Read data
  input wire logic [DATA_W-1:0] data_bus_out, // Data driven to memory
  input wire logic [DATA_W-1:0] data_bus_in, // Data from memory
  input wire logic chip_select_n, // Memory chip select
  input wire logic write_enable_n, // Memory write enable
  input wire logic output_enable_n, // Memory output enable
  input wire logic data_bus_oe, // High while driving data
  input wire logic upper_byte_lane_n, // Upper lane enable
  input wire logic lower_byte_lane_n // Lower lane enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    req_valid && req_ready && req_lane != 2'h0;
  endsequence
  sequence s_wr_end;
    $rose(write_enable_n);
  endsequence
  a_write_window: assert property (!write_enable_n |-> !chip_select_n &&
    !(upper_byte_lane_n && lower_byte_lane_n)) else $error("write without select or lane");
  a_read_no_drive: assert property (!output_enable_n |-> write_enable_n &&
    !data_bus_oe) else $error("drive or write while memory outputs on");
  a_write_drives: assert property (!write_enable_n |-> output_enable_n &&
    data_bus_oe) else $error("write pulse without data or with outputs on");
  a_select_before_end: assert property (s_wr_end |-> !$past(chip_select_n))
    else $error("select not low before write end");
  a_lane_before_end: assert property (s_wr_end |->
    !($past(upper_byte_lane_n) && $past(lower_byte_lane_n))) else $error("lane off before end");
  a_data_hold_end: assert property (s_wr_end |-> data_bus_oe && $stable(data_bus_out))
    else $error("data moved at write end");
  a_addr_stable: assert property (!chip_select_n && !$past(chip_select_n) |->
    $stable(address_bus)) else $error("address moved while selected");
  a_read_answer: assert property (s_take ##0 !req_write |-> ##[3:5] rsp_valid)
    else $error("read answer late");
  a_write_answer: assert property (s_take ##0 req_write |-> ##[4:6] wr_done)
    else $error("write end late");
  a_lanes_follow: assert property (s_take ##0 !req_write |=>
    {upper_byte_lane_n, lower_byte_lane_n} == ~$past(req_lane)) else $error("lane mismatch");
endmodule
bind asrc_sram_ctrl asrc_sram_ctrl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .req_valid(req_valid),
  .req_write(req_write),
  .req_ready(req_ready),
  .rsp_valid(rsp_valid),
  .wr_done(wr_done),
  .req_lane(req_lane),
  .req_addr(req_addr),
  .address_bus(address_bus),
  .req_wdata(req_wdata),
  .rsp_rdata(rsp_rdata),
  .data_bus_out(data_bus_out),
  .data_bus_in(data_bus_in),
  .chip_select_n(chip_select_n),
  .write_enable_n(write_enable_n),
  .output_enable_n(output_enable_n),
  .data_bus_oe(data_bus_oe),
  .upper_byte_lane_n(upper_byte_lane_n),
  .lower_byte_lane_n(lower_byte_lane_n)
);

// ### asrc_wait_timer.sv
`timescale 1ns/1ps
module asrc_wait_timer #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic load, // Start a new count
  input wire logic [WIDTH-1:0] load_value, // Cycles to wait
  output logic expired // High when count has run out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_value;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign expired = (count == '0) && !load;
endmodule

// ### test_async_sram_x16_access_timing.sv
`timescale 1ns/1ps
module test_async_sram_x16_access_timing;
  import asrc_pkg::*;
  logic core_clk, reset_n, req_valid, req_write, req_ready, rsp_valid, wr_done;
  logic cs_n, we_n, oe_n, ub_n, lb_n, d_oe, clash;
  logic [1:0] req_lane, q_en;
  logic [16:0] req_addr, abus;
  logic [15:0] req_wdata, rsp_rdata, d_out, d_in, q, last;
  logic [15:0] exp_mem [logic [16:0]];
  logic [31:0] seed;
  int bad_count, n_tests;
  always #20 core_clk = ~core_clk;
  // Released lanes show the inverse of the last value, never a lucky match
  assign d_in[7:0] = d_oe ? d_out[7:0] : q_en[0] ? q[7:0] : ~last[7:0];
  assign d_in[15:8] = d_oe ? d_out[15:8] : q_en[1] ? q[15:8] : ~last[15:8];
  always @(posedge core_clk) last <= d_in;
  asrc_sram_ctrl DUT (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lane(req_lane),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .wr_done(wr_done),
    .chip_select_n(cs_n), .write_enable_n(we_n), .output_enable_n(oe_n),
    .upper_byte_lane_n(ub_n), .lower_byte_lane_n(lb_n), .address_bus(abus),
    .data_bus_out(d_out), .data_bus_oe(d_oe), .data_bus_in(d_in));
  asrc_mem_model mem (.clk(core_clk), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .ub_n(ub_n),
    .lb_n(lb_n), .ctrl_oe(d_oe), .addr(abus), .wdata(d_in), .q(q), .q_en(q_en),
    .clash(clash));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] lane_mask(input logic [1:0] l);
    return {{8{l[1]}}, {8{l[0]}}};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic req(input logic wr, input logic [16:0] a, input logic [15:0] d,
                     input logic [1:0] l);
    int i;
    logic [15:0] old;
    i = 0;
    while (req_ready !== 1'b1 && i < 20) begin
      @(negedge core_clk);
      i++;
    end
    if (i == 20) begin
      bad_count++;
      end_sim();
    end
    {req_valid, req_write, req_addr, req_wdata, req_lane} = {1'b1, wr, a, d, l};
    @(negedge core_clk);
    req_valid = 1'b0;
    check(req_ready, l != 2'h0 ? 1'b0 : 1'b1);
    i = 0;
    while ((wr ? wr_done : rsp_valid) !== 1'b1 && i < 10) begin
      @(negedge core_clk);
      i++;
    end
    if (l == 2'h0) begin
      check(i, 10);
      return;
    end
    if (i == 10) begin
      bad_count++;
      end_sim();
    end
    old = exp_mem.exists(a) ? exp_mem[a] : 16'h0;
    if (wr) exp_mem[a] = (old & ~lane_mask(l)) | (d & lane_mask(l));
    else check(rsp_rdata, old & lane_mask(l));
  endtask
  initial begin
    {core_clk, reset_n, req_valid, req_write, req_addr, req_wdata, req_lane} = '0;
    {bad_count, n_tests, seed} = {32'h0, 32'h0, 32'h7B115B6F};
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    check({cs_n, we_n, oe_n, ub_n, lb_n, d_oe, req_ready}, 7'h7D);
    req(1'b1, 17'h1FFFF, 16'hA55A, 2'h3);
    req(1'b0, 17'h1FFFF, 16'h0, 2'h3);
    req(1'b1, 17'h0, 16'h1234, 2'h1);
    req(1'b1, 17'h0, 16'hABCD, 2'h2);
    for (int l = 1; l < 4; l++) req(1'b0, 17'h0, 16'h0, l[1:0]);
    repeat (80) begin
      seed = lfsr(seed);
      req(seed[0], {13'h0, seed[4:1]}, seed[31:16], seed[6:5]);
    end
    check(clash, 1'b0);
    end_sim();
  end
endmodule
